/* src/rbe_core.sv */
/*
  Bit-stream encoder, framing unit and 256-byte chunk FIFO with APB registers,
  level interrupt and a serial status byte shifted out at the start of every
  host serial access.
  Assumes the modem side runs on clk; serial select and clock come from the
  host asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`include "rbe_consts.svh"

// Notes on behaviour
// - encoder between framer and modem, both directions
// - inversion complements every bit
// - 4-FSK: separate low and high bit inversion
// - differential: zero keeps level, one toggles
// - Manchester: two line symbols per bit
// - whitening adds no bits
// - whitening polynomial selectable: nine, fifteen, seventeen
// - additive or multiplicative scrambling selectable
// - framer serialises tx, recovers rx bytes
// - packet or raw mode by configuration
// - single 256-byte buffer for host data
// - chunks: header holds length and type
// - rssi, offset, timestamp chunks into rx buffer
// - buffer direction follows tx or rx mode
// - maskable empty/nonempty/full/notfull/level interrupts
// - interrupt high while any enabled cause
// - interrupt clears only when cause removed or masked
// - status byte shifted out during address phase
// - raw mode: no delimiting, plain byte grouping
// - packet mode delimits with flag 0x7E
module rbe_core
  import rbe_pkg::*;
(
  input wire logic clk, // 200 MHz core clock
  input wire logic rst, // synchronous reset, active high
  input wire rbe_apb_req_t apb_req, // apb request
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire rbe_modem_in_t modem_in, // modem symbol strobes and rx symbol
  input wire rbe_meas_t [2:0] meas_in, // 0 rssi, 1 freq offset, 2 timestamp
  output logic tx_sym, // encoded tx line symbol
  output logic tx_busy, // framer has data in flight
  input wire logic spi_sel_n, // host select, active low, async
  input wire logic spi_sclk, // host serial clock, async
  output logic spi_miso, // serial status out
  output logic spi_miso_oe, // miso driven while selected
  output logic irq // level interrupt, active high
);

  rbe_state_t s, n;

  // --------------------------------------------------------------------------
  // whitening feedback
  // --------------------------------------------------------------------------
  function automatic logic wh_fb(input logic [16:0] st, input logic [1:0] sel);
    logic [16:0] m;
    m = (sel == 2'd0) ? `RBE_TAPS_NINE : (sel == 2'd1) ? `RBE_TAPS_FIFTEEN
      : `RBE_TAPS_SEVENTEEN;
    return ^(st & m);
  endfunction

  logic empty, full, above_thr, free_above;
  logic [7:0] stat_byte;
  logic [4:0] causes;
  logic setup, access, hit;
  logic [8:0] free_cnt;

  assign empty = (s.count == 9'h000);
  assign full = (s.count == `RBE_FIFO_FULL);
  assign free_cnt = `RBE_FIFO_FULL - s.count;
  assign above_thr = (s.count > s.thr);
  assign free_above = (free_cnt > s.thr);
  // empty, full, overrun, underrun, level, free space, msb first
  assign stat_byte = {empty, full, s.ovr, s.udr, above_thr, free_above, 2'b00};
  // empty, not empty, full, not full, level
  assign causes = {above_thr, ~full, full, ~empty, empty};
  assign irq = |(causes & s.irq_mask);

  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  always_comb begin
    if (apb_req.paddr == `RBE_OFS_CTRL) begin
      hit = 1'b1;
    end else if (apb_req.paddr == `RBE_OFS_DATA) begin
      hit = 1'b1;
    end else if (apb_req.paddr == `RBE_OFS_STAT) begin
      hit = 1'b1;
    end else if (apb_req.paddr == `RBE_OFS_THR) begin
      hit = 1'b1;
    end else if (apb_req.paddr == `RBE_OFS_MASK) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata = s.prdata;
  assign tx_sym = s.tx_sym;
  assign tx_busy = (s.tx_cnt != 4'h0) || (s.tx_st != TX_IDLE);
  assign spi_miso = s.spi_miso;
  assign spi_miso_oe = ~s.sel_s;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic push, pop, set_ovr, set_udr, sym, b, w, lvl, bit_ok, d, fb;
    logic [7:0] push_data, pop_data, sh;
    logic [2:0] ctype;
    n = s;
    push = 1'b0;
    pop = 1'b0;
    set_ovr = 1'b0;
    set_udr = 1'b0;
    push_data = 8'h00;
    pop_data = s.mem[s.rd_ptr];
    sym = 1'b0;
    b = 1'b0;
    w = 1'b0;
    lvl = 1'b0;
    bit_ok = 1'b0;
    d = 1'b0;
    fb = 1'b0;
    sh = 8'h00;
    ctype = 3'h0;

    // ---- apb ----
    if (setup) begin
      if (apb_req.paddr == `RBE_OFS_CTRL) begin
        n.prdata = {20'h0_0000, s.ctrl};
      end else if (apb_req.paddr == `RBE_OFS_DATA) begin
        n.prdata = (s.ctrl.tx || empty) ? 32'h0000_0000 : {24'h00_0000, pop_data};
      end else if (apb_req.paddr == `RBE_OFS_STAT) begin
        n.prdata = {15'h0000, s.count, stat_byte};
      end else if (apb_req.paddr == `RBE_OFS_THR) begin
        n.prdata = {23'h00_0000, s.thr};
      end else if (apb_req.paddr == `RBE_OFS_MASK) begin
        n.prdata = {27'h000_0000, s.irq_mask};
      end else begin
        n.prdata = 32'h0000_0000;
      end
    end
    if (access && apb_req.pwrite) begin
      if (apb_req.paddr == `RBE_OFS_CTRL) begin
        n.ctrl = rbe_ctrl_t'(apb_req.pwdata[`RBE_CTRL_W-1:0]);
      end else if (apb_req.paddr == `RBE_OFS_DATA) begin
        if (s.ctrl.tx) begin
          if (full) begin
            set_ovr = 1'b1;
          end else begin
            push = 1'b1;
            push_data = apb_req.pwdata[7:0];
          end
        end
      end else if (apb_req.paddr == `RBE_OFS_STAT) begin
        if (apb_req.pwdata[`RBE_STAT_OVR]) begin
          n.ovr = 1'b0;
        end
        if (apb_req.pwdata[`RBE_STAT_UDR]) begin
          n.udr = 1'b0;
        end
      end else if (apb_req.paddr == `RBE_OFS_THR) begin
        n.thr = apb_req.pwdata[8:0];
      end else if (apb_req.paddr == `RBE_OFS_MASK) begin
        n.irq_mask = apb_req.pwdata[4:0];
      end
    end
    if (access && !apb_req.pwrite && apb_req.paddr == `RBE_OFS_DATA && !s.ctrl.tx) begin
      if (empty) begin
        set_udr = 1'b1;
      end else begin
        pop = 1'b1;
      end
    end

    // ---- tx encoder: whiten, differential, manchester, invert ----
    if (s.ctrl.tx && modem_in.sym_tick) begin
      if (s.ctrl.manch && s.tx_half) begin
        sym = ~s.tx_mbit;
        n.tx_half = 1'b0;
      end else begin
        if (s.tx_cnt != 4'h0) begin
          b = s.tx_sh[0];
          n.tx_sh = {1'b0, s.tx_sh[7:1]};
          n.tx_cnt = s.tx_cnt - 4'h1;
        end
        w = b;
        if (s.ctrl.whiten) begin
          fb = wh_fb(s.tx_lfsr, s.ctrl.poly);
          w = b ^ fb;
          n.tx_lfsr = {s.tx_lfsr[15:0], s.ctrl.mult ? w : fb};
        end
        lvl = s.ctrl.diff ? (s.tx_lvl ^ w) : w;
        n.tx_lvl = lvl;
        sym = lvl;
        if (s.ctrl.manch) begin
          n.tx_mbit = lvl;
          n.tx_half = 1'b1;
        end
      end
      n.tx_sym = sym ^ s.ctrl.inv ^ (s.ctrl.fsk4 & (s.tx_phase ? s.ctrl.inv_lsb
        : s.ctrl.inv_msb));
      n.tx_phase = ~s.tx_phase;
    end

    // ---- tx framer ----
    if (s.ctrl.tx && n.tx_cnt == 4'h0) begin
      case (s.tx_st)
        TX_IDLE: begin
          if (!empty) begin
            if (!s.ctrl.raw) begin
              n.tx_sh = `RBE_HDLC_FLAG;
              n.tx_cnt = 4'h8;
            end
            n.tx_st = TX_HDR;
          end
        end
        TX_HDR: begin
          if (!empty) begin
            pop = 1'b1;
            n.tx_len = pop_data[4:0];
            n.tx_st = (pop_data[4:0] == 5'h00) ? TX_GAP : TX_DATA;
          end
        end
        TX_DATA: begin
          if (!empty) begin
            pop = 1'b1;
            n.tx_sh = pop_data;
            n.tx_cnt = 4'h8;
            n.tx_len = s.tx_len - 5'h01;
            if (s.tx_len == 5'h01) begin
              n.tx_st = TX_GAP;
            end
          end
        end
        TX_GAP: begin
          if (!empty) begin
            n.tx_st = TX_HDR;
          end else begin
            if (!s.ctrl.raw) begin
              n.tx_sh = `RBE_HDLC_FLAG;
              n.tx_cnt = 4'h8;
            end
            n.tx_st = TX_IDLE;
          end
        end
        default: n.tx_st = TX_IDLE;
      endcase
    end

    // ---- rx chunk sequencer ----
    for (int i = 0; i < 3; i++) begin
      if (!s.ctrl.tx && meas_in[i].stb) begin
        n.m_val[i] = meas_in[i].val;
      end
    end
    if (!s.ctrl.tx) begin
      case (s.sq_st)
        SQ_IDLE: begin
          if (s.rx_byte_pend) begin
            ctype = `RBE_CHUNK_DATA;
            n.sq_pay = s.rx_byte;
            n.rx_byte_pend = 1'b0;
          end else if (s.m_pend[0]) begin
            ctype = `RBE_CHUNK_RSSI;
            n.sq_pay = s.m_val[0];
            n.m_pend[0] = 1'b0;
          end else if (s.m_pend[1]) begin
            ctype = `RBE_CHUNK_FOFS;
            n.sq_pay = s.m_val[1];
            n.m_pend[1] = 1'b0;
          end else if (s.m_pend[2]) begin
            ctype = `RBE_CHUNK_TSTAMP;
            n.sq_pay = s.m_val[2];
            n.m_pend[2] = 1'b0;
          end
          if (ctype != 3'h0) begin
            push = 1'b1;
            push_data = {ctype, 5'h01};
            n.sq_st = SQ_PAY;
          end
        end
        SQ_PAY: begin
          push = 1'b1;
          push_data = s.sq_pay;
          n.sq_st = SQ_IDLE;
        end
        default: n.sq_st = SQ_IDLE;
      endcase
      for (int i = 0; i < 3; i++) begin
        if (meas_in[i].stb) begin
          n.m_pend[i] = 1'b1;
        end
      end
      if (push && full) begin
        push = 1'b0;
        set_ovr = 1'b1;
      end
    end

    // ---- rx decoder: invert, manchester, differential, dewhiten ----
    if (!s.ctrl.tx && modem_in.rx_sym_vld) begin
      sym = modem_in.rx_sym ^ s.ctrl.inv ^ (s.ctrl.fsk4 & (s.rx_phase ? s.ctrl.inv_lsb
        : s.ctrl.inv_msb));
      n.rx_phase = ~s.rx_phase;
      bit_ok = 1'b1;
      b = sym;
      if (s.ctrl.manch) begin
        if (!s.rx_half) begin
          n.rx_mbit = sym;
          n.rx_half = 1'b1;
          bit_ok = 1'b0;
        end else begin
          n.rx_half = 1'b0;
          b = s.rx_mbit;
        end
      end
      if (bit_ok) begin
        d = s.ctrl.diff ? (b ^ s.rx_prev) : b;
        n.rx_prev = b;
        w = d;
        if (s.ctrl.whiten) begin
          fb = wh_fb(s.rx_lfsr, s.ctrl.poly);
          w = d ^ fb;
          n.rx_lfsr = {s.rx_lfsr[15:0], s.ctrl.mult ? d : fb};
        end
        sh = {w, s.rx_sh[7:1]};
        n.rx_sh = sh;
        if (!s.ctrl.raw && sh == `RBE_HDLC_FLAG) begin
          n.rx_in_frame = 1'b1;
          n.rx_cnt = 4'h0;
        end else if (s.ctrl.raw || s.rx_in_frame) begin
          n.rx_cnt = s.rx_cnt + 4'h1;
          if (s.rx_cnt == 4'h7) begin
            n.rx_cnt = 4'h0;
            if (n.rx_byte_pend) begin
              set_ovr = 1'b1;
            end
            n.rx_byte = sh;
            n.rx_byte_pend = 1'b1;
          end
        end
      end
    end

    // ---- fifo storage ----
    if (push) begin
      n.mem[s.wr_ptr] = push_data;
      n.wr_ptr = s.wr_ptr + 8'h01;
    end
    if (pop) begin
      n.rd_ptr = s.rd_ptr + 8'h01;
    end
    n.count = s.count + {8'h00, push} - {8'h00, pop};
    if (set_ovr) begin
      n.ovr = 1'b1;
    end
    if (set_udr) begin
      n.udr = 1'b1;
    end

    // ---- serial status byte ----
    n.sel_m = spi_sel_n;
    n.sel_s = s.sel_m;
    n.sel_d = s.sel_s;
    n.sclk_m = spi_sclk;
    n.sclk_s = s.sclk_m;
    n.sclk_d = s.sclk_s;
    if (!s.sel_s && s.sel_d) begin
      n.spi_sh = {stat_byte[6:0], 1'b0};
      n.spi_miso = stat_byte[7];
      n.spi_cnt = 4'h1;
    end else if (!s.sel_s && !s.sclk_s && s.sclk_d) begin
      if (s.spi_cnt < 4'h8) begin
        n.spi_miso = s.spi_sh[7];
        n.spi_sh = {s.spi_sh[6:0], 1'b0};
        n.spi_cnt = s.spi_cnt + 4'h1;
      end else begin
        n.spi_miso = 1'b0;
      end
    end

    if (rst) begin
      n = '0;
      n.ctrl = rbe_ctrl_t'(`RBE_CTRL_RST);
      n.thr = `RBE_THR_RST;
      n.irq_mask = `RBE_MASK_RST;
      n.tx_lfsr = `RBE_LFSR_SEED;
      n.rx_lfsr = `RBE_LFSR_SEED;
      n.sel_m = 1'b1;
      n.sel_s = 1'b1;
      n.sel_d = 1'b1;
      n.tx_st = TX_IDLE;
      n.sq_st = SQ_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

endmodule // rbe_core

/* src/rbe_consts.svh */
/*
  Constants of the radio bit encoder and framing FIFO block: register offsets,
  field positions, reset values and whitening taps.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef RBE_CONSTS_SVH
`define RBE_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define RBE_OFS_CTRL 8'h00
`define RBE_OFS_DATA 8'h04
`define RBE_OFS_STAT 8'h08
`define RBE_OFS_THR 8'h0C
`define RBE_OFS_MASK 8'h10

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define RBE_CTRL_W 12
`define RBE_CTRL_RST 12'h000
`define RBE_THR_RST 9'h080
`define RBE_MASK_RST 5'h00
`define RBE_STAT_OVR 5
`define RBE_STAT_UDR 4
`define RBE_FIFO_DEPTH 256
`define RBE_FIFO_FULL 9'h100
`define RBE_HDLC_FLAG 8'h7E
`define RBE_CHUNK_DATA 3'h1
`define RBE_CHUNK_RSSI 3'h2
`define RBE_CHUNK_FOFS 3'h3
`define RBE_CHUNK_TSTAMP 3'h4

// ----------------------------------------------------------------------------
// whitening taps and seed
// ----------------------------------------------------------------------------
`define RBE_TAPS_NINE 17'h0_0110
`define RBE_TAPS_FIFTEEN 17'h0_6000
`define RBE_TAPS_SEVENTEEN 17'h1_0800
`define RBE_LFSR_SEED 17'h1_FFFF

`endif

/* src/rbe_pkg.sv */
/*
  Types of the radio bit encoder and framing FIFO block.
  Assumes rbe_consts.svh is reachable on the include path.
*/
`include "rbe_consts.svh"

package rbe_pkg;

  // --------------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rbe_apb_req_t;

  typedef struct packed {
    logic stb;
    logic [7:0] val;
  } rbe_meas_t;

  typedef struct packed {
    logic sym_tick;
    logic rx_sym;
    logic rx_sym_vld;
  } rbe_modem_in_t;

  // --------------------------------------------------------------------------
  // control register layout, msb first
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic mult;
    logic [1:0] poly;
    logic whiten;
    logic manch;
    logic diff;
    logic fsk4;
    logic inv_msb;
    logic inv_lsb;
    logic inv;
    logic raw;
    logic tx;
  } rbe_ctrl_t;

  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_DATA, TX_GAP} rbe_tx_st_t;
  typedef enum logic {SQ_IDLE, SQ_PAY} rbe_sq_st_t;

  // --------------------------------------------------------------------------
  // whole state of the block
  // --------------------------------------------------------------------------
  typedef struct packed {
    rbe_ctrl_t ctrl;
    logic [8:0] thr;
    logic [4:0] irq_mask;
    logic ovr;
    logic udr;
    logic [`RBE_FIFO_DEPTH-1:0][7:0] mem;
    logic [7:0] wr_ptr;
    logic [7:0] rd_ptr;
    logic [8:0] count;
    logic [31:0] prdata;
    logic sel_m, sel_s, sel_d, sclk_m, sclk_s, sclk_d;
    logic [7:0] spi_sh;
    logic [3:0] spi_cnt;
    logic spi_miso;
    rbe_tx_st_t tx_st;
    logic [4:0] tx_len;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_half, tx_mbit, tx_lvl, tx_phase, tx_sym;
    logic [16:0] tx_lfsr;
    logic rx_phase, rx_half, rx_mbit, rx_prev, rx_in_frame, rx_byte_pend;
    logic [16:0] rx_lfsr;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [7:0] rx_byte;
    rbe_sq_st_t sq_st;
    logic [7:0] sq_pay;
    logic [2:0] m_pend;
    logic [2:0][7:0] m_val;
  } rbe_state_t;

endpackage

/* tb/rbe_core_asserts.sv */
/*
  Port checker of rbe_core, bound into the core.
  Assumes one clock domain and the synchronous active-high reset.
*/
`timescale 1ns/1ps
module rbe_core_asserts
  import rbe_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire rbe_apb_req_t apb_req, // apb request
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire rbe_modem_in_t modem_in, // modem strobes
  input wire rbe_meas_t [2:0] meas_in, // measurements
  input wire logic tx_sym, // tx symbol
  input wire logic tx_busy, // framer busy
  input wire logic spi_sel_n, // select
  input wire logic spi_sclk, // serial clock
  input wire logic spi_miso, // status out
  input wire logic spi_miso_oe, // status enable
  input wire logic irq // interrupt
);
  logic access;
  logic mapped;
  logic quiet;
  assign access = apb_req.psel && apb_req.penable;
  assign mapped = apb_req.paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  assign quiet = !apb_req.psel && !modem_in.sym_tick && !modem_in.rx_sym_vld
    && !meas_in[0].stb && !meas_in[1].stb && !meas_in[2].stb;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  reset_quiet_a: assert property (
    disable iff (1'b0) rst |=> !irq && !tx_busy && !spi_miso_oe && prdata == 32'h0000_0000)
    else $error("outputs not idle after reset");
  tx_on_tick_a: assert property ($changed(tx_sym) |-> $past(modem_in.sym_tick))
    else $error("tx symbol moved without a tick");
  sel_oe_on_a: assert property ($fell(spi_sel_n) |-> ##[1:4] spi_miso_oe)
    else $error("status line not driven after select");
  sel_oe_off_a: assert property (spi_sel_n [*4] |-> !spi_miso_oe)
    else $error("status line driven while deselected");
  miso_steady_a: assert property ((spi_sclk && !spi_sel_n) [*6] |=> $stable(spi_miso))
    else $error("status bit moved without a falling serial clock");
  bad_addr_a: assert property (access && !mapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  good_addr_a: assert property (access && mapped |-> !pslverr)
    else $error("mapped access refused");
  read_hold_a: assert property (!(apb_req.psel && !apb_req.penable) |=> $stable(prdata))
    else $error("read data moved without a setup");
  irq_masked_a: assert property (
    access && apb_req.pwrite && apb_req.paddr == 8'h10 && apb_req.pwdata[4:0] == 5'h00 |=> !irq)
    else $error("interrupt high with all causes masked");
  irq_level_a: assert property ((irq && quiet) [*4] |=> irq)
    else $error("interrupt dropped with no cause removed");
endmodule // rbe_core_asserts

bind rbe_core rbe_core_asserts rbe_core_asserts_inst (.clk, .rst, .apb_req, .prdata, .pready,
  .pslverr, .modem_in, .meas_in, .tx_sym, .tx_busy, .spi_sel_n, .spi_sclk, .spi_miso,
  .spi_miso_oe, .irq);

/* tb/rbe_spi_host.sv */
/*
  Host side of the serial status path: one select, eight clocks, msb first.
  Assumes the core clock; the serial clock stands still outside frames.
*/
`timescale 1ns/1ps
module rbe_spi_host (
  input wire logic clk, // core clock
  input wire logic start, // pulse: run one frame
  input wire logic miso, // resolved status line
  output logic sel_n, // select, active low
  output logic sclk, // serial clock, 160 ns period in frames
  output logic [7:0] status, // captured byte
  output logic done // pulse: frame complete
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    status = 8'h00;
    done = 1'b0;
    forever begin
      @(posedge clk);
      done <= 1'b0;
      if (start) begin
        sel_n <= 1'b0;
        repeat (16) @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
          sclk <= 1'b1;
          repeat (16) @(posedge clk);
          status[i] <= miso;
          sclk <= 1'b0;
          repeat (16) @(posedge clk);
        end
        sel_n <= 1'b1;
        done <= 1'b1;
      end
    end
  end
endmodule // rbe_spi_host

/* tb/rbe_core_tb_top.sv */
/*
  Testbench of rbe_core: apb tasks, modem strobes, serial status host.
  Assumes the core, the host model and the bound checker are compiled.
*/
`timescale 1ns/1ps
`include "rbe_consts.svh"
module rbe_core_tb_top;
  import rbe_pkg::*;
  logic clk;
  logic rst;
  rbe_apb_req_t apb_req;
  logic [31:0] prdata;
  logic pready, pslverr, tx_sym, tx_busy, spi_sel_n, spi_sclk, spi_miso, spi_miso_oe, irq;
  rbe_modem_in_t modem_in;
  rbe_meas_t [2:0] meas_in;
  logic spi_start;
  logic spi_done;
  logic [7:0] spi_status;
  logic [31:0] rd;
  logic serr;
  int n_errors;
  int comparisons;
  logic [11:0] cfg [11] = '{12'h001, 12'h003, 12'h007, 12'h043, 12'h083, 12'h0C7, 12'h033,
    12'h02B, 12'h103, 12'h503, 12'hB03};
  logic [7:0] rx_exp [8] = '{8'h21, 8'h3C, 8'h41, 8'h50, 8'h61, 8'h51, 8'h81, 8'h52};
  // pull-up on the released status line
  wire miso_line = spi_miso_oe ? spi_miso : 1'b1;

  rbe_core rbe_core_inst (.clk, .rst, .apb_req, .prdata, .pready, .pslverr, .modem_in,
    .meas_in, .tx_sym, .tx_busy, .spi_sel_n, .spi_sclk, .spi_miso, .spi_miso_oe, .irq);
  rbe_spi_host rbe_spi_host_inst (.clk(clk), .start(spi_start), .miso(miso_line),
    .sel_n(spi_sel_n), .sclk(spi_sclk), .status(spi_status), .done(spi_done));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    serr = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic irq_scan(input logic [4:0] cause);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'h10, 32'(1 << i));
      repeat (5) @(posedge clk);
      check(32'(irq), 32'(cause[i]));
    end
    apb(1'b1, 8'h10, 32'h0000_0000);
  endtask

  task automatic spi_poll(input logic [7:0] exp);
    @(posedge clk);
    spi_start <= 1'b1;
    @(posedge clk);
    spi_start <= 1'b0;
    for (int n = 0; n < 800 && spi_done !== 1'b1; n++) @(posedge clk);
    if (spi_done !== 1'b1) n_errors++;
    check(32'(spi_status), 32'(exp));
  endtask

  task automatic tick_tx(output logic s);
    @(posedge clk);
    modem_in.sym_tick <= 1'b1;
    @(posedge clk);
    modem_in.sym_tick <= 1'b0;
    @(posedge clk);
    s = tx_sym;
    @(posedge clk);
  endtask

  task automatic rx_bits(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      modem_in <= '{sym_tick: 1'b0, rx_sym: b[i], rx_sym_vld: 1'b1};
      @(posedge clk);
      modem_in.rx_sym_vld <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  // one chunk of one byte through the selected coding
  task automatic tx_case(input logic [11:0] ctrl);
    logic [23:0] bits;
    logic [16:0] lf;
    logic lvl;
    logic s;
    logic e;
    logic w;
    logic f;
    int nb;
    int k;
    do_reset();
    apb(1'b1, 8'h00, {20'h0_0000, ctrl});
    apb(1'b1, 8'h04, 32'h0000_0021);
    apb(1'b1, 8'h04, 32'h0000_00A5);
    check(32'(tx_busy), 32'h0000_0001);
    bits = ctrl[1] ? 24'h00_00A5 : 24'h7E_A57E;
    nb = ctrl[1] ? 8 : 24;
    lvl = 1'b0;
    lf = `RBE_LFSR_SEED;
    k = 0;
    for (int i = 0; i < nb; i++) begin
      w = bits[i];
      if (ctrl[8]) begin
        f = ^(lf & (ctrl[10:9] == 2'd0 ? `RBE_TAPS_NINE
          : ctrl[10:9] == 2'd1 ? `RBE_TAPS_FIFTEEN : `RBE_TAPS_SEVENTEEN));
        lf = {lf[15:0], ctrl[11] ? w ^ f : f};
        w = w ^ f;
      end
      lvl = ctrl[6] ? lvl ^ w : w;
      for (int h = 0; h <= int'(ctrl[7]); h++) begin
        tick_tx(s);
        e = (h == 1 ? ~lvl : lvl) ^ ctrl[2];
        if (ctrl[5]) e = e ^ (k[0] ? ctrl[3] : ctrl[4]);
        check(32'(s), 32'(e));
        k++;
      end
    end
    check(32'(tx_busy), 32'h0000_0000);
  endtask

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    apb_req = '0;
    modem_in = '0;
    meas_in = '0;
    spi_start = 1'b0;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h00, 32'h0000_0000);
    rchk(8'h0C, 32'h0000_0080);
    rchk(8'h08, 32'h0000_0084);
    rchk(8'h14, 32'h0000_0000);
    check(32'(serr), 32'h0000_0001);
    irq_scan(5'b0_1001);
    spi_poll(8'h84);
    apb(1'b1, 8'h00, 32'h0000_0001);
    for (int i = 0; i < 256; i++) apb(1'b1, 8'h04, 32'(i));
    apb(1'b1, 8'h04, 32'h0000_00AA);
    rchk(8'h08, 32'h0001_0068);
    irq_scan(5'b1_0110);
    rchk(8'h04, 32'h0000_0000);
    apb(1'b1, 8'h08, 32'h0000_0020);
    spi_poll(8'h48);
    apb(1'b1, 8'h00, 32'h0000_0000);
    for (int i = 0; i < 256; i++) rchk(8'h04, 32'(i[7:0]));
    rchk(8'h04, 32'h0000_0000);
    rchk(8'h08, 32'h0000_0094);
    foreach (cfg[j]) tx_case(cfg[j]);
    do_reset();
    rx_bits(8'h7E);
    rx_bits(8'h96);
    repeat (4) @(posedge clk);
    rchk(8'h08, 32'h0000_0204);
    rchk(8'h04, 32'h0000_0021);
    rchk(8'h04, 32'h0000_0096);
    do_reset();
    apb(1'b1, 8'h00, 32'h0000_0002);
    rx_bits(8'h3C);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      meas_in[i] <= '{stb: 1'b1, val: 8'h50 + 8'(i)};
      @(posedge clk);
      meas_in[i].stb <= 1'b0;
      repeat (3) @(posedge clk);
    end
    foreach (rx_exp[j]) rchk(8'h04, {24'h00_0000, rx_exp[j]});
    finish_test();
  end

  initial begin
    #200_000;
    n_errors++;
    finish_test();
  end
endmodule // rbe_core_tb_top
